// [wpc_wake_power_control.sv]
/*
 * wake and power control register with event flag, pme output,
 * power-down and clock-rate selects, and a small interrupt block.
 * assumes bus strobes and wake pulses are on ref_clk; power-good,
 * bus reset, aux power and the eeprom defaults are asynchronous pins.
 */
// How it works
// - Low power-good puts the register back to its initial value.
// - Without aux power a bus reset release also resets it.
// - The apm enable bit opens the advanced wakeup path.
// - Bit 1 is a read/write alias of the bus event-enable bit.
// - Bit 2 is set by any wakeup and mirrors the bus event flag.
// - Writing one to bit 2 clears the flag; zero leaves it.
// - Bit 3 plus apm enable lets a pattern match set flag and pme.
// - Bit 3 takes its initial value from the eeprom.
// - Bit 28 turns on dynamic powerdown, reset zero.
// - Bit 29 allows half rate at gigabit on a 33 MHz bus.
// - Bit 30 allows quarter rate at other link rates.
// - Both bits zero leaves the rate to the frequency selects.
// - Bit 31 puts the mac into smart powerdown.
// - The frequency field takes its initial value from the eeprom.
`timescale 1ns/1ps
`include "wpc_cfg.svh"

module wpc_wake_power_control
  import wpc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [`WPC_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [31:0]            rdata,
  input  wire logic                   lan_power_good,
  input  wire logic                   bus_rst_n,
  input  wire logic                   aux_power,
  input  wire logic                   ee_apm_sig,
  input  wire logic [1:0]             ee_freq,
  input  wire logic                   cfg_pm_en_wr,
  input  wire logic                   cfg_pm_en_val,
  input  wire logic                   cfg_pm_flag_clr,
  input  wire logic                   wake_event,
  input  wire logic                   pattern_match,
  input  wire logic                   bus_is_33mhz,
  input  wire logic                   link_is_gig,
  input  wire logic [1:0]             mac_freq_sel,
  output logic                        pm_event_enable,
  output logic                        pm_event_flag,
  output logic                        pme_n,
  output logic                        dyn_powerdown,
  output logic                        smart_powerdown,
  output logic      [1:0]             mac_clk_div,
  output logic                        irq
);

  // pin synchronisers: power-good, bus reset, aux power, eeprom straps
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [1:0] sync1_f;
  logic [1:0] sync2_f;
  logic       bus_rst_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // bus reset flops start at idle high: no false rise after rst
      sync1     <= `WPC_SYNC_IDLE;
      sync2     <= `WPC_SYNC_IDLE;
      sync1_f   <= 2'h0;
      sync2_f   <= 2'h0;
      bus_rst_q <= `WPC_BRST_IDLE;
    end else begin
      sync1     <= {lan_power_good, bus_rst_n, aux_power, ee_apm_sig, 1'b0};
      sync2     <= sync1;
      sync1_f   <= ee_freq;
      sync2_f   <= sync1_f;
      bus_rst_q <= sync2[3];
    end
  end

  logic pg_s;
  logic brst_s;
  logic aux_s;
  logic ee_apm_s;
  logic reg_reset;
  assign pg_s     = sync2[4];
  assign brst_s   = sync2[3];
  assign aux_s    = sync2[2];
  assign ee_apm_s = sync2[1];

  assign reg_reset = !pg_s || (!aux_s && brst_s && !bus_rst_q);

  // register fields
  logic      apm_wake_enable;
  logic      apm_wake_signal_enable;
  wpc_freq_t auto_freq;
  wpc_irq_t  irq_status;
  wpc_irq_t  irq_mask;
  logic      next_apm_wake_enable;
  logic      next_pm_event_enable;
  logic      next_pm_event_flag;
  logic      next_apm_wake_signal_enable;
  logic      next_dyn_powerdown;
  wpc_freq_t next_auto_freq;
  logic      next_smart_powerdown;
  logic      next_pme_n;
  wpc_irq_t  next_irq_status;
  wpc_irq_t  next_irq_mask;
  logic      next_irq;
  logic [1:0] next_mac_clk_div;
  logic [31:0] next_rdata;
  logic [31:0] ctrl_view;
  logic      apm_hit;
  logic      wr_ctrl;

  assign wr_ctrl = wr_en && (addr == `WPC_OFF_CTRL);
  // pattern match gated by both enables
  assign apm_hit = pattern_match && apm_wake_enable && apm_wake_signal_enable;

  always_comb begin
    ctrl_view = `WPC_ZERO32;
    ctrl_view[`WPC_BIT_APM_EN]   = apm_wake_enable;
    ctrl_view[`WPC_BIT_PM_EN]    = pm_event_enable;
    ctrl_view[`WPC_BIT_PM_FLAG]  = pm_event_flag;
    ctrl_view[`WPC_BIT_APM_SIG]  = apm_wake_signal_enable;
    ctrl_view[`WPC_BIT_DYN_PD]   = dyn_powerdown;
    ctrl_view[`WPC_BIT_FREQ_HI:`WPC_BIT_FREQ_LO] = auto_freq;
    ctrl_view[`WPC_BIT_SMART_PD] = smart_powerdown;
  end

  always_comb begin
    next_apm_wake_enable        = apm_wake_enable;
    next_pm_event_enable        = pm_event_enable;
    next_pm_event_flag          = pm_event_flag;
    next_apm_wake_signal_enable = apm_wake_signal_enable;
    next_dyn_powerdown          = dyn_powerdown;
    next_auto_freq              = auto_freq;
    next_smart_powerdown        = smart_powerdown;
    next_irq_mask               = irq_mask;
    next_irq_status             = irq_status;
    if (reg_reset) begin
      next_apm_wake_enable        = `WPC_RST_BIT;
      next_pm_event_enable        = `WPC_RST_BIT;
      next_pm_event_flag          = `WPC_RST_BIT;
      next_apm_wake_signal_enable = ee_apm_s;
      next_dyn_powerdown          = `WPC_RST_BIT;
      next_auto_freq              = sync2_f;
      next_smart_powerdown        = `WPC_RST_BIT;
    end else begin
      if (wr_ctrl) begin
        next_apm_wake_enable        = wdata[`WPC_BIT_APM_EN];
        next_pm_event_enable        = wdata[`WPC_BIT_PM_EN];
        next_apm_wake_signal_enable = wdata[`WPC_BIT_APM_SIG];
        next_dyn_powerdown          = wdata[`WPC_BIT_DYN_PD];
        next_auto_freq = wdata[`WPC_BIT_FREQ_HI:`WPC_BIT_FREQ_LO];
        next_smart_powerdown        = wdata[`WPC_BIT_SMART_PD];
      end
      if (cfg_pm_en_wr) begin
        next_pm_event_enable = cfg_pm_en_val;
      end
      if ((wr_ctrl && wdata[`WPC_BIT_PM_FLAG]) || cfg_pm_flag_clr) begin
        next_pm_event_flag = 1'b0;
      end
      if (wake_event || apm_hit) begin
        next_pm_event_flag = 1'b1;
      end
    end
    if (wr_en && addr == `WPC_OFF_IRQ_MASK) begin
      next_irq_mask = wdata[`WPC_IRQ_W-1:0];
    end
    if (wr_en && addr == `WPC_OFF_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wdata[`WPC_IRQ_W-1:0];
    end
    if (wake_event || apm_hit) begin
      next_irq_status[`WPC_IRQ_WAKE] = 1'b1;
    end
    if (apm_hit) begin
      next_irq_status[`WPC_IRQ_APM] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
    // pme asserted while flag and enable, or flag with both apm enable bits set
    next_pme_n = !((next_pm_event_flag && next_pm_event_enable) ||
                   (next_pm_event_flag && next_apm_wake_signal_enable &&
                    next_apm_wake_enable));
    if (next_auto_freq == `WPC_RST_FREQ) begin
      next_mac_clk_div = mac_freq_sel;
    end else if (link_is_gig) begin
      next_mac_clk_div = (next_auto_freq[0] && bus_is_33mhz) ? 2'h1 : 2'h0;
    end else begin
      next_mac_clk_div = next_auto_freq[1] ? 2'h2 : 2'h0;
    end
    next_rdata = `WPC_ZERO32;
    if (rd_en) begin
      case (addr)
        `WPC_OFF_CTRL:       next_rdata = ctrl_view;
        `WPC_OFF_IRQ_STATUS: next_rdata = {30'h0, irq_status};
        `WPC_OFF_IRQ_MASK:   next_rdata = {30'h0, irq_mask};
        default:             next_rdata = `WPC_ZERO32;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      apm_wake_enable        <= 1'b0;
      pm_event_enable        <= 1'b0;
      pm_event_flag          <= 1'b0;
      apm_wake_signal_enable <= 1'b0;
      dyn_powerdown          <= 1'b0;
      auto_freq              <= 2'h0;
      smart_powerdown        <= 1'b0;
      pme_n                  <= 1'b1;
      irq_status             <= 2'h0;
      irq_mask               <= 2'h0;
      irq                    <= 1'b0;
      mac_clk_div            <= 2'h0;
      rdata                  <= 32'h0000_0000;
    end else begin
      apm_wake_enable        <= next_apm_wake_enable;
      pm_event_enable        <= next_pm_event_enable;
      pm_event_flag          <= next_pm_event_flag;
      apm_wake_signal_enable <= next_apm_wake_signal_enable;
      dyn_powerdown          <= next_dyn_powerdown;
      auto_freq              <= next_auto_freq;
      smart_powerdown        <= next_smart_powerdown;
      pme_n                  <= next_pme_n;
      irq_status             <= next_irq_status;
      irq_mask               <= next_irq_mask;
      irq                    <= next_irq;
      mac_clk_div            <= next_mac_clk_div;
      rdata                  <= next_rdata;
    end
  end

endmodule

// [wpc_cfg.svh]
/*
 * constants for the wake and power control register block.
 * assumes inclusion by the package and the block module only.
 */
`ifndef WPC_CFG_SVH
`define WPC_CFG_SVH

`define WPC_ADDR_W          16
`define WPC_OFF_CTRL        16'h5800
`define WPC_OFF_IRQ_STATUS  16'h5900
`define WPC_OFF_IRQ_MASK    16'h5904

`define WPC_BIT_APM_EN      0
`define WPC_BIT_PM_EN       1
`define WPC_BIT_PM_FLAG     2
`define WPC_BIT_APM_SIG     3
`define WPC_BIT_DYN_PD      28
`define WPC_BIT_FREQ_LO     29
`define WPC_BIT_FREQ_HI     30
`define WPC_BIT_SMART_PD    31

`define WPC_RST_BIT         1'h0
`define WPC_RST_FREQ        2'h0
`define WPC_ZERO32          32'h0000_0000
`define WPC_SYNC_IDLE       5'h08
`define WPC_BRST_IDLE       1'h1

`define WPC_IRQ_W           2
`define WPC_IRQ_WAKE        0
`define WPC_IRQ_APM         1

`endif

// [wpc_pkg.sv]
/*
 * types for the wake and power control register block.
 * assumes wpc_cfg.svh holds every number.
 */
`include "wpc_cfg.svh"

package wpc_pkg;
  typedef logic [1:0] wpc_freq_t;
  typedef logic [`WPC_IRQ_W-1:0] wpc_irq_t;
endpackage

// [wpc_wake_power_control_properties.sv]
/* port checker for the wake control block.
   assumes one clock ref_clk and async reset rst. */
`timescale 1ns/1ps
module wpc_wake_power_control_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        lan_power_good,
  input wire logic        bus_rst_n,
  input wire logic        wake_event,
  input wire logic        pattern_match,
  input wire logic        cfg_pm_en_wr,
  input wire logic        cfg_pm_en_val,
  input wire logic        link_is_gig,
  input wire logic        pm_event_enable,
  input wire logic        pm_event_flag,
  input wire logic        pme_n,
  input wire logic        dyn_powerdown,
  input wire logic        smart_powerdown,
  input wire logic [1:0]  mac_clk_div
);
  logic [2:0] ok_cnt;
  logic [2:0] next_ok_cnt;
  logic       quiet;
  logic       wr_ctrl;
  // register reset settles a few edges after the pins rise
  always_comb begin
    next_ok_cnt = 3'h0;
    if (lan_power_good && bus_rst_n)
      next_ok_cnt = ok_cnt + {2'h0, ok_cnt != 3'h7};
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      ok_cnt <= 3'h0;
    else
      ok_cnt <= next_ok_cnt;
  end
  assign quiet = ok_cnt == 3'h7;
  assign wr_ctrl = quiet && wr_en && addr == 16'h5800;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_pg; !lan_power_good [*5] |->
    !pm_event_enable && !dyn_powerdown && !smart_powerdown; endproperty
  a_pg: assert property (p_pg) else $error("no power-good reset");
  property p_cfg_en; quiet && cfg_pm_en_wr |=>
    pm_event_enable == $past(cfg_pm_en_val); endproperty
  a_cfg_en: assert property (p_cfg_en) else $error("alias lost");
  property p_wake; quiet && wake_event |=> pm_event_flag; endproperty
  a_wake: assert property (p_wake) else $error("wake flag lost");
  property p_w1c; wr_ctrl && wdata[2] && !wake_event && !pattern_match
    |=> !pm_event_flag; endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_pme_idle; !pm_event_flag |-> pme_n; endproperty
  a_pme_idle: assert property (p_pme_idle) else $error("stray pme");
  property p_pm_event_enable; pm_event_flag && pm_event_enable |-> !pme_n; endproperty
  a_pm_event_enable: assert property (p_pm_event_enable) else $error("pme missing");
  property p_pd; wr_ctrl |=> {smart_powerdown, dyn_powerdown} ==
    {$past(wdata[31]), $past(wdata[28])}; endproperty
  a_pd: assert property (p_pd) else $error("powerdown bits");
  property p_quarter; wr_ctrl && wdata[30] && !link_is_gig |=>
    mac_clk_div == 2'h2; endproperty
  a_quarter: assert property (p_quarter) else $error("no quarter");
  c_pme: cover property (!pme_n);
  c_wake: cover property (quiet && wake_event);
  c_pg: cover property ($fell(lan_power_good));
endmodule

bind wpc_wake_power_control wpc_wake_power_control_chk u_chk (.*);

// [wpc_host_pm.sv]
/* host power-management side: config writes, bus reset, aux supply.
   assumes tasks are called by the bench between clock edges. */
`timescale 1ns/1ps
module wpc_host_pm (
  input  wire logic ref_clk,
  output logic      cfg_pm_en_wr = 1'b0,
  output logic      cfg_pm_en_val = 1'b0,
  output logic      cfg_pm_flag_clr = 1'b0,
  output logic      bus_rst_n = 1'b1,
  output logic      aux_power = 1'b1
);
  task automatic cfg(input logic w, input logic v, input logic c);
    @(posedge ref_clk);
    cfg_pm_en_wr    <= w;
    cfg_pm_en_val   <= v;
    cfg_pm_flag_clr <= c;
    @(posedge ref_clk);
    cfg_pm_en_wr    <= 1'b0;
    cfg_pm_flag_clr <= 1'b0;
    #1;
  endtask
  task automatic bus_reset(input logic aux);
    @(posedge ref_clk);
    aux_power <= aux;
    bus_rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    bus_rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
endmodule

// [wpc_wake_power_control_tb_top.sv]
/* bench for the wake control block with the host model.
   assumes the port checker is bound into the block. */
`timescale 1ns/1ps
module wpc_wake_power_control_tb_top;
  logic        ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic        lan_power_good = 1'b0, ee_apm_sig = 1'b1, irq, pme_n;
  logic        wake_event = 1'b0, pattern_match = 1'b0, pm_event_flag;
  logic        bus_is_33mhz = 1'b1, link_is_gig = 1'b1, pm_event_enable;
  logic        cfg_pm_en_wr, cfg_pm_en_val, cfg_pm_flag_clr;
  logic        bus_rst_n, aux_power, dyn_powerdown, smart_powerdown;
  logic [1:0]  ee_freq = 2'h2, mac_freq_sel = 2'h3, mac_clk_div;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata;
  int          err_count = 0, compares = 0;
  initial forever #25 ref_clk = ~ref_clk;
  wpc_wake_power_control u_wpc_wake_power_control (.*);
  wpc_host_pm u_wpc_host_pm (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic ev(input logic pat);
    @(posedge ref_clk);
    wake_event    <= !pat;
    pattern_match <= pat;
    @(posedge ref_clk);
    wake_event    <= 1'b0;
    pattern_match <= 1'b0;
    #1;
  endtask
  task automatic pg_cycle();
    @(posedge ref_clk);
    lan_power_good <= 1'b0;
    repeat (6) @(posedge ref_clk);
    lan_power_good <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    pg_cycle();
    rd(16'h5800, 32'h4000_0008);
    chk(pme_n, 1'b1);
    wr(16'h5800, 32'hffff_ffff);
    rd(16'h5800, 32'hf000_000b);
    chk({smart_powerdown, dyn_powerdown}, 2'h3);
    chk(mac_clk_div, 2'h1);
    bus_is_33mhz <= 1'b0;
    wr(16'h5800, 32'h2000_0000);
    chk(mac_clk_div, 2'h0);
    bus_is_33mhz <= 1'b1;
    link_is_gig <= 1'b0;
    wr(16'h5800, 32'h4000_0000);
    chk(mac_clk_div, 2'h2);
    wr(16'h5800, 32'h0);
    rd(16'h5800, 32'h0);
    chk(mac_clk_div, 2'h3);
    wr(16'h5800, 32'h0000_0008);
    ev(1'b1);
    chk(pm_event_flag, 1'b0);
    wr(16'h5800, 32'h0000_0009);
    ev(1'b1);
    chk({pm_event_flag, pme_n}, 2'h2);
    wr(16'h5800, 32'h0000_0009);
    rd(16'h5800, 32'h0000_000d);
    wr(16'h5800, 32'h0000_0004);
    rd(16'h5800, 32'h0);
    u_wpc_host_pm.cfg(1'b1, 1'b1, 1'b0);
    rd(16'h5800, 32'h0000_0002);
    ev(1'b0);
    chk({pm_event_flag, pme_n}, 2'h2);
    rd(16'h5800, 32'h0000_0006);
    u_wpc_host_pm.cfg(1'b0, 1'b0, 1'b1);
    chk(pm_event_flag, 1'b0);
    wr(16'h5900, 32'h3);
    ev(1'b0);
    rd(16'h5900, 32'h1);
    chk(irq, 1'b0);
    wr(16'h5904, 32'h1);
    rd(16'h5904, 32'h1);
    chk(irq, 1'b1);
    wr(16'h5900, 32'h1);
    rd(16'h5900, 32'h0);
    chk(irq, 1'b0);
    rd(16'h5804, 32'h0);
    wr(16'h5800, 32'h1000_0005);
    u_wpc_host_pm.bus_reset(1'b1);
    rd(16'h5800, 32'h1000_0001);
    u_wpc_host_pm.bus_reset(1'b0);
    rd(16'h5800, 32'h4000_0008);
    ee_apm_sig <= 1'b0;
    ee_freq    <= 2'h1;
    pg_cycle();
    rd(16'h5800, 32'h2000_0000);
    end_of_test();
  end
endmodule
